/* verilog/rcb_cfg.svh */
// register offsets, field positions, reset values and counts of the sequencer
// assumes inclusion by bare name from the package and the top module
`ifndef RCB_CFG_SVH
`define RCB_CFG_SVH

// register byte offsets on the apb bus
`define RCB_OFS_PLL_CTRL   12'h000
`define RCB_OFS_SW_RESET   12'h004
`define RCB_OFS_STATUS     12'h008
`define RCB_OFS_BOOT_VEC   12'h00c

// pll control register fields
`define RCB_PLL_MULT_LSB   0
`define RCB_PLL_MULT_MSB   6
`define RCB_PLL_DIV_BIT    7
`define RCB_PLL_HALF_BIT   8
`define RCB_PLL_BYP_BIT    9
`define RCB_PLL_PDALL_BIT  10

// software reset register: writing one here restarts the core
`define RCB_SWRST_BIT      0

// status register fields
`define RCB_ST_MODE_LSB    0
`define RCB_ST_MODE_MSB    2
`define RCB_ST_LEGAL_BIT   3
`define RCB_ST_PLLRUN_BIT  4
`define RCB_ST_PDALL_BIT   5
`define RCB_ST_WAKE_BIT    6
`define RCB_ST_BUSW_BIT    7
`define RCB_ST_RUN_BIT     8

// reset values
`define RCB_PLL_MULT_RST   7'h00
`define RCB_PLL_DIV_RST    1'b0
`define RCB_PLL_HALF_RST   1'b1
`define RCB_BOOT_VECTOR    24'hff0000

// timing counts, in core cycles
`define RCB_PLL_RESTABLE_CYC 500
`define RCB_POR_HOLD_CYC     512

`endif

/* verilog/rcb_pkg.sv */
// types shared by the reset, clock and boot sequencer
// assumes rcb_cfg.svh is on the include path
`include "rcb_cfg.svh"

package rcb_pkg;

  // sequencer states
  typedef enum logic [2:0] {
    RCB_HOLD,
    RCB_SWRST,
    RCB_BUSWAIT,
    RCB_BOOT,
    RCB_RUN,
    RCB_PDALL,
    RCB_WAKE
  } rcb_state_type;

  // boot-select strap codes
  typedef enum logic [2:0] {
    RCB_BM_RSV0,
    RCB_BM_EXT8_BOOT,
    RCB_BM_EXT8_EXEC,
    RCB_BM_EXT16_EXEC,
    RCB_BM_SPI_SMALL,
    RCB_BM_SPI_LARGE,
    RCB_BM_RSV6,
    RCB_BM_RSV7
  } rcb_boot_mode_type;

  // pll control register contents
  typedef struct packed {
    logic       pd_all_sel;
    logic       bypass;
    logic       ratio_half;
    logic       input_divide_flag;
    logic [6:0] pll_multiplier_select;
  } rcb_pll_ctrl_type;

  // apb request as seen by the slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rcb_apb_req_type;

  // clock and reset outputs toward the rest of the chip
  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic clock_output_pin;
    logic pll_run;
    logic pbus_halt;
    logic pipe_flush;
    logic master_rst;
    logic boot_nmi;
  } rcb_ctl_out_type;

endpackage

/* verilog/rcb_sequencer.sv */
// reset, clock and boot sequencer: apb slave, power-down-all, pll setup, boot vectoring
// assumes one 200 mhz clock, synchronous straps and an external analog pll and por sensor
// Notes on behaviour
// R01: power-down-all stops core, peripheral clock and pll, flushes pipe, halts bus.
// R02: interrupt in power-down-all waits 500 cycles for pll before core resumes.
// R03: seven-bit multiplier select gives 128 input-to-core clock ratios.
// R04: reset factor from bypass pin, multiplier field and divide flag; software may change.
// R05: software sets divide flag above 100 mhz input, clears it below.
// R06: peripheral clock drives the clock output pin and all peripherals; the pin here toggles per tick, at half the peripheral rate.
// R07: peripheral clock is core clock or half of it, by ratio select bit.
// R08: software keeps core at most 160 mhz and peripheral at most 80 mhz.
// R09: reset input low gives complete hardware reset of the whole device.
// R10: internal power-on reset output asserted at power-up and on supply drop.
// R11: reset source holds reset 512 cycles after oscillator start for pll lock.
// R12: master reset empties stacks, masks interrupts, restores register defaults.
// R13: after release with no bus request pending, jump to boot rom at 0xff0000.
// R14: hardware and software reset both raise the nonmaskable boot interrupt.
// R15: execution always starts at boot rom address whatever the boot pins.
// R16: boot-select pins sampled at hardware reset, three-bit mode held for rom.
// R17: codes 1,2,3 are external 8-bit boot, 8-bit and 16-bit execute.
// R18: codes 4,5 are small and large spi boot; 0,6,7 reserved.
// R19: software reset keeps the previously sampled boot mode.
`include "rcb_cfg.svh"

module rcb_sequencer
  import rcb_pkg::*;
#(
  parameter int RESTABLE_CYC = `RCB_PLL_RESTABLE_CYC,
  parameter int POR_HOLD_CYC = `RCB_POR_HOLD_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output      logic [31:0] PRDATA,
  output      logic        PREADY,
  output      logic        PSLVERR,
  // straps and board signals
  input  wire logic        BYPASS_PIN,
  input  wire logic        BOOT_SELECT_BIT2,
  input  wire logic        BOOT_SELECT_BIT1,
  input  wire logic        BOOT_SELECT_BIT0,
  input  wire logic        SUPPLY_OK,
  output      logic        POR_N,
  // core handshakes
  input  wire logic        IDLE_REQ,
  input  wire logic        WAKE_IRQ,
  input  wire logic        BUS_REQ,
  // clock, reset and boot outputs
  output      logic        CORE_CLK_EN,
  output      logic        PERIPH_CLK_EN,
  output      logic        CLOCK_OUTPUT_PIN,
  output      logic        PLL_RUN,
  output      logic [6:0]  PLL_MULT,
  output      logic        PLL_DIVIDE,
  output      logic        PLL_BYPASS,
  output      logic        PBUS_HALT,
  output      logic        PIPE_FLUSH,
  output      logic        MASTER_RST,
  output      logic        BOOT_NMI,
  output      logic [23:0] BOOT_VECTOR,
  output      logic [2:0]  BOOT_MODE
);

  localparam logic [9:0] RESTABLE_LAST = 10'(RESTABLE_CYC - 1);
  localparam logic [9:0] POR_LAST      = 10'(POR_HOLD_CYC - 1);

  // the whole state of the block
  typedef struct packed {
    rcb_state_type     state;
    rcb_pll_ctrl_type  pll;
    rcb_boot_mode_type boot_mode;
    logic              straps_taken;
    logic [9:0]        wake_cnt;
    logic [9:0]        por_cnt;
    logic              por_n;
    logic              phase;
    rcb_ctl_out_type   ctl;
    logic [31:0]       prdata;
    logic              pslverr;
  } rcb_seq_type;

  localparam rcb_pll_ctrl_type PLL_RST = '{
    pd_all_sel:            1'b0,
    bypass:                1'b0,
    ratio_half:            `RCB_PLL_HALF_RST,
    input_divide_flag:     `RCB_PLL_DIV_RST,
    pll_multiplier_select: `RCB_PLL_MULT_RST
  };

  // hardware reset holds every output in its quiet state, pll running
  localparam rcb_ctl_out_type CTL_RST = '{
    core_clk_en:      1'b0,
    periph_clk_en:    1'b0,
    clock_output_pin: 1'b0,
    pll_run:          1'b1,
    pbus_halt:        1'b1,
    pipe_flush:       1'b1,
    master_rst:       1'b1,
    boot_nmi:         1'b0
  };

  rcb_seq_type     seq_r;
  rcb_seq_type     seq_nxt;
  rcb_apb_req_type req;
  logic            apb_setup;
  logic            apb_write;
  logic            addr_hit;
  logic            sw_reset_req;
  logic            core_on;
  logic [31:0]     rd_word;

  assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};

  // apb decode; the slave never inserts wait states
  assign apb_setup = req.psel & ~req.penable;
  assign apb_write = req.psel & req.penable & req.pwrite;
  assign addr_hit  = (req.paddr == `RCB_OFS_PLL_CTRL) | (req.paddr == `RCB_OFS_SW_RESET) |
                     (req.paddr == `RCB_OFS_STATUS)   | (req.paddr == `RCB_OFS_BOOT_VEC);
  assign sw_reset_req = apb_write & (req.paddr == `RCB_OFS_SW_RESET) &
                        req.pwdata[`RCB_SWRST_BIT];

  // read multiplexer, sampled in the setup phase so data is a flop in the access phase
  always_comb begin
    rd_word = 32'h0;
    if (req.paddr == `RCB_OFS_PLL_CTRL) begin
      rd_word[`RCB_PLL_MULT_MSB:`RCB_PLL_MULT_LSB] = seq_r.pll.pll_multiplier_select;
      rd_word[`RCB_PLL_DIV_BIT]   = seq_r.pll.input_divide_flag;
      rd_word[`RCB_PLL_HALF_BIT]  = seq_r.pll.ratio_half;
      rd_word[`RCB_PLL_BYP_BIT]   = seq_r.pll.bypass;
      rd_word[`RCB_PLL_PDALL_BIT] = seq_r.pll.pd_all_sel;
    end else if (req.paddr == `RCB_OFS_STATUS) begin
      rd_word[`RCB_ST_MODE_MSB:`RCB_ST_MODE_LSB] = seq_r.boot_mode; // R16
      rd_word[`RCB_ST_LEGAL_BIT]  = (seq_r.boot_mode != RCB_BM_RSV0) &&
                                    (seq_r.boot_mode != RCB_BM_RSV6) &&
                                    (seq_r.boot_mode != RCB_BM_RSV7); // R18
      rd_word[`RCB_ST_PLLRUN_BIT] = seq_r.ctl.pll_run;
      rd_word[`RCB_ST_PDALL_BIT]  = (seq_r.state == RCB_PDALL);
      rd_word[`RCB_ST_WAKE_BIT]   = (seq_r.state == RCB_WAKE);
      rd_word[`RCB_ST_BUSW_BIT]   = (seq_r.state == RCB_BUSWAIT);
      rd_word[`RCB_ST_RUN_BIT]    = (seq_r.state == RCB_RUN);
    end else if (req.paddr == `RCB_OFS_BOOT_VEC) begin
      rd_word[23:0] = `RCB_BOOT_VECTOR;
    end
  end

  // next state of the whole block
  always_comb begin
    seq_nxt = seq_r;
    seq_nxt.ctl.boot_nmi   = 1'b0;
    seq_nxt.ctl.pipe_flush = 1'b0;

    // apb read data and error, both taken in the setup phase
    if (apb_setup) begin
      seq_nxt.prdata  = rd_word;
      seq_nxt.pslverr = ~addr_hit;
    end

    // run-time change of the pll setup by software
    if (apb_write && (req.paddr == `RCB_OFS_PLL_CTRL)) begin
      seq_nxt.pll.pll_multiplier_select =
        req.pwdata[`RCB_PLL_MULT_MSB:`RCB_PLL_MULT_LSB]; // R03 R04
      seq_nxt.pll.input_divide_flag = req.pwdata[`RCB_PLL_DIV_BIT]; // R04 R05
      seq_nxt.pll.ratio_half        = req.pwdata[`RCB_PLL_HALF_BIT]; // R07
      seq_nxt.pll.bypass            = req.pwdata[`RCB_PLL_BYP_BIT]; // R04
      seq_nxt.pll.pd_all_sel        = req.pwdata[`RCB_PLL_PDALL_BIT];
    end

    // sequencer
    unique case (seq_r.state)
      RCB_HOLD: begin
        // straps are caught on the first edge after release, never under reset
        if (!seq_r.straps_taken) begin
          seq_nxt.boot_mode    = rcb_boot_mode_type'({BOOT_SELECT_BIT2, BOOT_SELECT_BIT1,
                                                      BOOT_SELECT_BIT0}); // R16 R17 R18
          seq_nxt.pll.bypass   = BYPASS_PIN; // R04
          seq_nxt.straps_taken = 1'b1;
        end
        seq_nxt.state = RCB_BUSWAIT;
      end
      RCB_SWRST: begin
        // boot mode deliberately untouched here
        seq_nxt.state = RCB_BUSWAIT; // R19
      end
      RCB_BUSWAIT: begin
        // a pending external bus request delays the jump to the boot rom
        if (!BUS_REQ) begin
          seq_nxt.state          = RCB_BOOT; // R13
          seq_nxt.ctl.boot_nmi   = 1'b1; // R14
          seq_nxt.ctl.master_rst = 1'b0;
          seq_nxt.ctl.pbus_halt  = 1'b0;
        end
      end
      RCB_BOOT: begin
        seq_nxt.state = RCB_RUN; // R15
      end
      RCB_RUN: begin
        if (IDLE_REQ && seq_r.pll.pd_all_sel) begin
          seq_nxt.state          = RCB_PDALL; // R01
          seq_nxt.ctl.pll_run    = 1'b0; // R01
          seq_nxt.ctl.pbus_halt  = 1'b1; // R01
          seq_nxt.ctl.pipe_flush = 1'b1; // R01
        end
      end
      RCB_PDALL: begin
        if (WAKE_IRQ) begin
          seq_nxt.state       = RCB_WAKE; // R02
          seq_nxt.ctl.pll_run = 1'b1;
          seq_nxt.wake_cnt    = 10'h000;
        end
      end
      RCB_WAKE: begin
        // pll restart time: core stays stopped until the count is done
        if (seq_r.wake_cnt == RESTABLE_LAST) begin
          seq_nxt.state         = RCB_RUN; // R02
          seq_nxt.ctl.pbus_halt = 1'b0;
        end else begin
          seq_nxt.wake_cnt = seq_r.wake_cnt + 10'h001; // R02
        end
      end
    endcase

    // software reset wins over anything else the core was doing
    if (sw_reset_req) begin
      seq_nxt.state          = RCB_SWRST; // R14
      seq_nxt.ctl.master_rst = 1'b1; // R12
      seq_nxt.ctl.pbus_halt  = 1'b1;
      seq_nxt.ctl.pipe_flush = 1'b1;
      seq_nxt.ctl.pll_run    = 1'b1;
    end

    // clock enables: core and peripheral ticks follow the next state
    core_on = (seq_nxt.state == RCB_BOOT) || (seq_nxt.state == RCB_RUN); // R01
    seq_nxt.ctl.core_clk_en = core_on;
    seq_nxt.phase = core_on ? ~seq_r.phase : 1'b0;
    seq_nxt.ctl.periph_clk_en = core_on & (~seq_r.pll.ratio_half | seq_r.phase); // R07
    // pin toggles per peripheral tick: it shows half the peripheral rate,
    // the cost of keeping one clock domain and no gated clock
    if (seq_nxt.ctl.periph_clk_en) begin
      seq_nxt.ctl.clock_output_pin = ~seq_r.ctl.clock_output_pin; // R06
    end

    // hardware reset: every field but por_cnt and por_n back to default, straps to be caught again
    if (!RST_N) begin
      seq_nxt.state        = RCB_HOLD; // R09
      seq_nxt.pll          = PLL_RST; // R12
      seq_nxt.boot_mode    = RCB_BM_RSV0;
      seq_nxt.straps_taken = 1'b0; // R16
      seq_nxt.wake_cnt     = 10'h000;
      seq_nxt.phase        = 1'b0;
      seq_nxt.ctl          = CTL_RST; // R12
      seq_nxt.prdata       = 32'h0;
      seq_nxt.pslverr      = 1'b0;
    end

    // power-on reset generator is fed by the supply sensor, not by the reset pin,
    // so that looping its output back onto the reset pin cannot lock it up
    if (!SUPPLY_OK) begin
      seq_nxt.por_cnt = 10'h000; // R10
      seq_nxt.por_n   = 1'b0; // R10
    end else if (seq_r.por_cnt != POR_LAST) begin
      seq_nxt.por_cnt = seq_r.por_cnt + 10'h001;
      seq_nxt.por_n   = 1'b0;
    end else begin
      seq_nxt.por_n = 1'b1; // R10
    end
  end

  // single state register; the synchronous reset is folded into the next value
  always_ff @(posedge CLK) begin
    seq_r <= seq_nxt;
  end

  // ports
  assign PRDATA           = seq_r.prdata;
  assign PREADY           = 1'b1;
  assign PSLVERR          = seq_r.pslverr & PSEL & PENABLE;
  assign POR_N            = seq_r.por_n;
  assign CORE_CLK_EN      = seq_r.ctl.core_clk_en;
  assign PERIPH_CLK_EN    = seq_r.ctl.periph_clk_en; // R06
  assign CLOCK_OUTPUT_PIN = seq_r.ctl.clock_output_pin;
  assign PLL_RUN          = seq_r.ctl.pll_run; // R01
  assign PLL_MULT         = seq_r.pll.pll_multiplier_select; // R03
  assign PLL_DIVIDE       = seq_r.pll.input_divide_flag;
  assign PLL_BYPASS       = seq_r.pll.bypass;
  assign PBUS_HALT        = seq_r.ctl.pbus_halt;
  assign PIPE_FLUSH       = seq_r.ctl.pipe_flush;
  assign MASTER_RST       = seq_r.ctl.master_rst; // R12
  assign BOOT_NMI         = seq_r.ctl.boot_nmi;
  assign BOOT_VECTOR      = `RCB_BOOT_VECTOR; // R15
  assign BOOT_MODE        = seq_r.boot_mode;

endmodule

/* testbench/rcb_board.sv */
// board model: reset source with optional por loopback, strap pins, supply sensor
// assumes the bench moves the board controls right after rising clock edges
module rcb_board (
  input  wire logic       ext_rst_n,
  input  wire logic       por_loop,
  input  wire logic [2:0] strap,
  input  wire logic       strap_bypass,
  input  wire logic       supply_good,
  input  wire logic       POR_N,
  output      logic       RST_N,
  output      logic       BOOT_SELECT_BIT2,
  output      logic       BOOT_SELECT_BIT1,
  output      logic       BOOT_SELECT_BIT0,
  output      logic       BYPASS_PIN,
  output      logic       SUPPLY_OK
);
  // por output wired back to reset, so reset lasts the whole por hold
  assign RST_N = ext_rst_n & (por_loop ? POR_N : 1'b1);
  // straps are static resistors, only legal codes matter to the rom
  assign {BOOT_SELECT_BIT2, BOOT_SELECT_BIT1, BOOT_SELECT_BIT0} = strap;
  assign BYPASS_PIN = strap_bypass;
  assign SUPPLY_OK = supply_good;
endmodule

/* testbench/rcb_sequencer_sva.sv */
// checker for the reset, clock and boot sequencer ports
// assumes it is bound into every rcb_sequencer instance
module rcb_sequencer_sva #(
  parameter int RESTABLE_CYC = 500,
  parameter int POR_HOLD_CYC = 512
) (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        BUS_REQ,
  input wire logic        SUPPLY_OK,
  input wire logic        POR_N,
  input wire logic        CORE_CLK_EN,
  input wire logic        PERIPH_CLK_EN,
  input wire logic        CLOCK_OUTPUT_PIN,
  input wire logic        PLL_RUN,
  input wire logic        PBUS_HALT,
  input wire logic        PIPE_FLUSH,
  input wire logic        MASTER_RST,
  input wire logic        BOOT_NMI,
  input wire logic [23:0] BOOT_VECTOR,
  input wire logic [2:0]  BOOT_MODE
);
  logic [9:0] wake_cnt_r;
  logic [9:0] por_cnt_r;
  logic       waking_r;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // long waits counted here, a repetition that long would not unroll
  always_ff @(posedge CLK) begin
    if (!RST_N || !PLL_RUN) wake_cnt_r <= 10'h000;
    else if (!CORE_CLK_EN) wake_cnt_r <= wake_cnt_r + 10'h001;
    if (!RST_N) waking_r <= 1'b0;
    else if (!PLL_RUN) waking_r <= 1'b1;
    else if (CORE_CLK_EN) waking_r <= 1'b0;
    if (!SUPPLY_OK) por_cnt_r <= 10'h000;
    else if (!POR_N) por_cnt_r <= por_cnt_r + 10'h001;
  end

  // release with no bus request pending, then the boot start
  sequence s_rel_free;
    $rose(RST_N) ##1 !BUS_REQ;
  endsequence
  sequence s_boot_up;
    BOOT_NMI && CORE_CLK_EN && !MASTER_RST && !PBUS_HALT;
  endsequence

  property p_pd_stop; !PLL_RUN |-> !CORE_CLK_EN && !PERIPH_CLK_EN && PBUS_HALT; endproperty
  property p_pd_flush; $fell(PLL_RUN) |-> PIPE_FLUSH ##1 !PIPE_FLUSH; endproperty
  property p_wake;
    waking_r && $rose(CORE_CLK_EN) |-> wake_cnt_r inside {[RESTABLE_CYC-1:RESTABLE_CYC+1]};
  endproperty
  property p_clock_output_pin; $changed(CLOCK_OUTPUT_PIN) |-> PERIPH_CLK_EN || $past(PERIPH_CLK_EN); endproperty
  property p_rst_hold; $rose(RST_N) |-> MASTER_RST && PBUS_HALT && !CORE_CLK_EN; endproperty
  property p_boot; s_rel_free |=> ##[0:1] s_boot_up; endproperty
  property p_bus_hold; BUS_REQ && MASTER_RST |=> !BOOT_NMI; endproperty
  property p_nmi; BOOT_NMI |-> BOOT_VECTOR == 24'hff0000 ##1 !BOOT_NMI; endproperty
  property p_mode_keep; $past(RST_N) && $past(RST_N, 2) |-> $stable(BOOT_MODE); endproperty
  property p_por;
    $rose(POR_N) |-> por_cnt_r inside {[POR_HOLD_CYC-1:POR_HOLD_CYC+1]};
  endproperty

  a_pd_stop: assert property (p_pd_stop) else $error("clock or bus alive, pll off");
  a_pd_flush: assert property (p_pd_flush) else $error("no flush pulse at pd entry");
  a_wake: assert property (p_wake) else $error("core resumed at wrong count");
  a_clock_output_pin: assert property (p_clock_output_pin) else $error("clock pin moved without tick");
  a_rst_hold: assert property (p_rst_hold) else $error("reset state not held");
  a_boot: assert property (p_boot) else $error("boot did not start");
  a_bus_hold: assert property (p_bus_hold) else $error("boot despite bus request");
  a_nmi: assert property (p_nmi) else $error("boot pulse or vector wrong");
  a_mode_keep: assert property (p_mode_keep) else $error("boot mode changed in run");
  a_por: assert property (p_por) else $error("por hold count wrong");
endmodule

bind rcb_sequencer rcb_sequencer_sva #(.RESTABLE_CYC(RESTABLE_CYC), .POR_HOLD_CYC(POR_HOLD_CYC))
  u_sva (.CLK(CLK), .RST_N(RST_N), .BUS_REQ(BUS_REQ), .SUPPLY_OK(SUPPLY_OK), .POR_N(POR_N),
  .CORE_CLK_EN(CORE_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN), .PLL_RUN(PLL_RUN),
  .CLOCK_OUTPUT_PIN(CLOCK_OUTPUT_PIN), .PBUS_HALT(PBUS_HALT), .PIPE_FLUSH(PIPE_FLUSH),
  .MASTER_RST(MASTER_RST), .BOOT_NMI(BOOT_NMI), .BOOT_VECTOR(BOOT_VECTOR),
  .BOOT_MODE(BOOT_MODE));

/* testbench/rcb_sequencer_test.sv */
// self-checking bench for the reset, clock and boot sequencer
// assumes the board model beside the design and the bound checker
module rcb_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RS = 4;  // short pll settle count
  localparam int PH = 4;  // short por hold count
  typedef struct packed {
    logic [2:0] code;
    logic       byp;
    logic [6:0] mult;
    logic       legal;
  } rcb_row_type;
  logic        clk, psel, penable, pwrite, idle_req, wake_irq, bus_req, err_q;
  logic        ext_rst_n, por_loop, strap_bypass, supply_good, pready, pslverr, por_n, rst_n;
  logic        bs2, bs1, bs0, byp_pin, sup_ok, core_en, per_en, clk_out, pll_run, pll_div;
  logic        pll_byp, pbus_halt, pipe_flush, master_rst, boot_nmi;
  logic [2:0]  strap, boot_mode;
  logic [6:0]  pll_mult;
  logic [11:0] paddr;
  logic [23:0] boot_vec;
  logic [31:0] pwdata, prdata, rd_q;
  int          bad_count, num_checks, n, t, g;
  // every strap code, with bypass strap and multiplier values spread over the field
  rcb_row_type rows [8] = '{'{3'h0, 1'b0, 7'h00, 1'b0}, '{3'h1, 1'b1, 7'h01, 1'b1},
    '{3'h2, 1'b0, 7'h1f, 1'b1}, '{3'h3, 1'b1, 7'h20, 1'b1}, '{3'h4, 1'b0, 7'h3f, 1'b1},
    '{3'h5, 1'b1, 7'h40, 1'b1}, '{3'h6, 1'b0, 7'h7e, 1'b0}, '{3'h7, 1'b1, 7'h7f, 1'b0}};

  rcb_sequencer #(.RESTABLE_CYC(RS), .POR_HOLD_CYC(PH)) uut (.CLK(clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BYPASS_PIN(byp_pin),
    .BOOT_SELECT_BIT2(bs2), .BOOT_SELECT_BIT1(bs1), .BOOT_SELECT_BIT0(bs0),
    .SUPPLY_OK(sup_ok), .POR_N(por_n), .IDLE_REQ(idle_req), .WAKE_IRQ(wake_irq),
    .BUS_REQ(bus_req), .CORE_CLK_EN(core_en), .PERIPH_CLK_EN(per_en),
    .CLOCK_OUTPUT_PIN(clk_out), .PLL_RUN(pll_run), .PLL_MULT(pll_mult), .PLL_DIVIDE(pll_div),
    .PLL_BYPASS(pll_byp), .PBUS_HALT(pbus_halt), .PIPE_FLUSH(pipe_flush),
    .MASTER_RST(master_rst), .BOOT_NMI(boot_nmi), .BOOT_VECTOR(boot_vec),
    .BOOT_MODE(boot_mode));
  rcb_board u_board (.ext_rst_n(ext_rst_n), .por_loop(por_loop), .strap(strap),
    .strap_bypass(strap_bypass), .supply_good(supply_good), .POR_N(por_n), .RST_N(rst_n),
    .BOOT_SELECT_BIT2(bs2), .BOOT_SELECT_BIT1(bs1), .BOOT_SELECT_BIT0(bs0),
    .BYPASS_PIN(byp_pin), .SUPPLY_OK(sup_ok));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: pick = boot_nmi;
      1: pick = core_en;
      2: pick = pll_run;
      3: pick = por_n;
      default: pick = master_rst;
    endcase
  endfunction

  // bounded wait for one watched output to be high
  task automatic wait_bit(input int k, input int lim, output int c);
    c = 0;
    while (pick(k) !== 1'b1 && c < lim) begin
      @(posedge clk);
      c++;
    end
  endtask

  task automatic do_reset(input logic [2:0] code, input logic byp);
    @(posedge clk);
    strap <= code;
    strap_bypass <= byp;
    ext_rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    ext_rst_n <= 1'b1;
  endtask

  // input clock below 100 mhz, so divide flag stays clear and limits hold
  function automatic logic [31:0] ctrl(input logic pd, byp, half, input logic [6:0] m);
    return {21'h0, pd, byp, half, 1'b0, m};
  endfunction

  // peripheral ticks and clock pin edges over 40 core cycles
  task automatic count_ticks();
    logic prev;
    t = 0;
    g = 0;
    prev = clk_out;
    repeat (40) begin
      @(posedge clk);
      if (per_en === 1'b1) t++;
      if (clk_out !== prev) g++;
      prev = clk_out;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    {psel, penable, pwrite, idle_req, wake_irq, bus_req, ext_rst_n, por_loop} = 8'h00;
    {strap_bypass, supply_good, strap, paddr, pwdata} = '0;
    repeat (6) @(posedge clk);
    check("rst_state", 32'h00000007, {core_en, master_rst, pbus_halt, pipe_flush});
    supply_good <= 1'b1;
    ext_rst_n <= 1'b1;
    wait_bit(3, 20, n);
    foreach (rows[i]) begin
      do_reset(rows[i].code, rows[i].byp);
      wait_bit(0, 10, n);
      check("boot_nmi", 32'h1, boot_nmi);
      check("boot_vector", 32'h00ff0000, boot_vec);
      check("boot_mode", rows[i].code, boot_mode);
      check("pll_reset", {rows[i].byp, 8'h00}, {pll_byp, pll_div, pll_mult});
      apb(1'b0, 12'h008, 32'h0);
      check("status_mode", {rows[i].legal, rows[i].code}, rd_q[3:0]);
      apb(1'b1, 12'h000, ctrl(1'b0, rows[i].byp, 1'b1, rows[i].mult));
      repeat (2) @(posedge clk);
      check("pll_mult", rows[i].mult, pll_mult);
      apb(1'b0, 12'h000, 32'h0);
      check("pll_ctrl", ctrl(1'b0, rows[i].byp, 1'b1, rows[i].mult), rd_q);
    end
    // peripheral rate at half and then full core rate
    count_ticks();
    check("ticks_half", 32'd20, t);
    check("pin_half", 32'd20, g);
    apb(1'b1, 12'h000, ctrl(1'b0, 1'b1, 1'b0, 7'h7f));
    repeat (2) @(posedge clk);
    count_ticks();
    check("ticks_full", 32'd40, t);
    check("pin_full", 32'd40, g);
    // power-down-all entry, then wake and pll settle
    apb(1'b1, 12'h000, ctrl(1'b1, 1'b1, 1'b0, 7'h7f));
    idle_req <= 1'b1;
    @(posedge clk);
    idle_req <= 1'b0;
    repeat (3) @(posedge clk);
    check("pd_all", 32'h1, {pll_run, core_en, per_en, pbus_halt});
    wake_irq <= 1'b1;
    wait_bit(2, 10, n);
    wake_irq <= 1'b0;
    wait_bit(1, 50, n);
    check("wake_wait", 32'h1, n >= RS && n <= RS + 1);
    // software reset with a bus request pending and changed straps
    strap <= 3'h2;
    bus_req <= 1'b1;
    apb(1'b1, 12'h004, 32'h1);
    wait_bit(4, 4, n);
    check("sw_master_rst", 32'h1, master_rst);
    wait_bit(0, 8, n);
    check("bus_hold", 32'd8, n);
    bus_req <= 1'b0;
    wait_bit(0, 6, n);
    check("sw_boot_nmi", 32'h1, boot_nmi);
    check("sw_boot_mode", 32'h7, boot_mode);
    // unmapped and read-only places
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped_err", 32'h1, {rd_q[30:0], err_q});
    apb(1'b0, 12'h00c, 32'h0);
    check("vector_reg", 32'h00ff0000, rd_q);
    // supply drop with por looped back to reset
    por_loop <= 1'b1;
    supply_good <= 1'b0;
    repeat (3) @(posedge clk);
    check("por_low", 32'h0, {por_n, rst_n});
    supply_good <= 1'b1;
    wait_bit(3, 20, n);
    check("por_hold", 32'h1, n >= PH && n <= PH + 2);
    wait_bit(0, 10, n);
    check("por_boot", 32'h1, boot_nmi);
    give_verdict();
  end
endmodule
